// ===== core/serial_evt_pkg.sv
// Constants, register map and carrier types for the two-channel serial event block
package serial_evt_pkg;
   localparam int ADDR_W = 22;
   localparam int IDX_W  = 20;
   localparam int NCH    = 2;

   // Register indexes; byte address is four times the index
   localparam logic [NCH-1:0][IDX_W-1:0] IDX_TX_HOLD   = {20'h401e5, 20'h401e0};
   localparam logic [NCH-1:0][IDX_W-1:0] IDX_RX_HOLD   = {20'h401e6, 20'h401e1};
   localparam logic [NCH-1:0][IDX_W-1:0] IDX_STATUS    = {20'h401e7, 20'h401e2};
   localparam logic [NCH-1:0][IDX_W-1:0] IDX_CONTROL   = {20'h401e8, 20'h401e3};
   localparam logic [NCH-1:0][IDX_W-1:0] IDX_IR_OPTION = {20'h401e9, 20'h401e4};
   localparam logic [NCH-1:0][IDX_W-1:0] IDX_PRIORITY  = {20'h40264, 20'h40263};
   localparam logic [NCH-1:0][IDX_W-1:0] IDX_DMA_SEL   = {20'h40293, 20'h40292};
   localparam logic [IDX_W-1:0]          IDX_ENABLES   = 20'h40276;
   localparam logic [IDX_W-1:0]          IDX_FLAGS     = 20'h40286;

   // Control register fields
   localparam int CTL_TX_ON    = 7;
   localparam int CTL_RX_ON    = 6;
   localparam int CTL_PAR_ON   = 5;
   localparam int CTL_PAR_SNS  = 4;
   localparam int CTL_STOP_LEN = 3;
   localparam int CTL_CLK_SRC  = 2;
   localparam int CTL_MODE_LO  = 0;
   localparam logic [1:0] MODE_ASYNC8 = 2'h3;
   localparam logic [1:0] MODE_ASYNC7 = 2'h2;
   localparam logic [1:0] MODE_SYNC_SLAVE  = 2'h1;
   localparam logic [1:0] MODE_SYNC_MASTER = 2'h0;

   // Infrared option fields
   localparam int IR_W        = 5;
   localparam int IR_DIV      = 4;
   localparam int IR_OUT_INV  = 3;
   localparam int IR_IN_INV   = 2;
   localparam int IR_MODE_LO  = 0;
   localparam logic [1:0] IFM_IRDA  = 2'h2;
   localparam logic [1:0] IFM_PLAIN = 2'h0;

   // Status fields
   localparam int ST_FER  = 4;
   localparam int ST_PER  = 3;
   localparam int ST_OER  = 2;
   localparam int ST_TDBE = 1;
   localparam int ST_RDBF = 0;

   // Event flag layout: three per channel
   localparam int EV_ERR    = 0;
   localparam int EV_RX     = 1;
   localparam int EV_TX     = 2;
   localparam int EV_STRIDE = 3;
   localparam int NEV       = 6;

   // Priority field positions, DMA select bit positions (rx, tx) per channel
   localparam logic [NCH-1:0][2:0] PRI_LO    = {3'h0, 3'h4};
   localparam logic [NCH-1:0][2:0] DMA_RX_BIT = {3'h0, 3'h6};
   localparam logic [NCH-1:0][2:0] DMA_TX_BIT = {3'h1, 3'h7};
   // DMA request order: ch0 rx, ch0 tx, ch1 rx, ch1 tx
   localparam logic [3:0][7:0] DMA_CH_NUM = {8'h1a, 8'h19, 8'h18, 8'h17};

   // Vector offset of the first source within the trap table, step between sources
   localparam logic [27:0] VEC_FIRST_OFS = 28'h00000e0;
   localparam logic [27:0] VEC_STEP      = 28'h0000004;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef struct packed {
      logic       done;
      logic [7:0] data;
      logic       parity;
      logic [1:0] stop;
   } rx_event_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } tx_feed_t;

   typedef struct packed {
      logic       transmitter_on;
      logic       receiver_on;
      logic       parity_on;
      logic       parity_sense;
      logic       stop_length;
      logic [1:0] transfer_mode_field;
      logic       async_divider_select;
      logic [1:0] interface_mode_field;
   } chan_cfg_t;

   typedef struct packed {
      logic [7:0]      tx_hold;
      logic [7:0]      rx_hold;
      logic [7:0]      ctl;
      logic [IR_W-1:0] ir;
      logic            fer;
      logic            per;
      logic            oer;
      logic            tx_empty;
      logic            rx_full;
   } chan_t;

   localparam chan_t CHAN_RESET = '{tx_hold: 8'h00, rx_hold: 8'h00, ctl: 8'h00,
                                    ir: 5'h00, fer: 1'b0, per: 1'b0, oer: 1'b0,
                                    tx_empty: 1'b1, rx_full: 1'b0};

   typedef struct packed {
      chan_t [NCH-1:0]      ch;
      logic [NCH-1:0][2:0]  pri;
      logic [NEV-1:0]       en;
      logic [NEV-1:0]       flg;
      logic [3:0]           dma_sel;
      logic [3:0]           dma_req;
      logic [7:0]           dma_chan;
      logic                 irq_req;
      logic [2:0]           irq_level;
      logic [27:0]          irq_vector;
      logic                 aw_got;
      logic [ADDR_W-1:0]    awaddr;
      logic                 w_got;
      logic [7:0]           wdata;
      logic                 wstrb0;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 rvalid;
      logic [7:0]           rdata;
      logic [1:0]           rresp;
      logic [NCH-1:0]       rx_s1;
      logic [NCH-1:0]       rx_s2;
      logic [NCH-1:0]       ck_s1;
      logic [NCH-1:0]       ck_s2;
      logic [NCH-1:0]       rx_line;
      logic [NCH-1:0]       tx_pin;
      logic [NCH-1:0]       shclk;
   } state_t;
endpackage : serial_evt_pkg

// ===== core/serial_evt_regs.sv
// Two-channel serial register file with event flags, interrupt selection and DMA triggers
//
// How it works
// RULE1: Byte moving to shift register sets tx-empty status and its event flag.
// RULE2: Completed reception loads rx holding, sets rx-full status and event flag.
// RULE3: Parity, framing or overrun fault sets the channel's shared fault event flag.
// RULE4: Clock-synchronized modes never report parity or framing faults, only overrun.
// RULE5: Parity or framing fault raises fault and rx-full events together, fault first.
// RULE6: Flags set regardless of enables; requests forwarded only when enabled. DMA triggers here ignore the enable bits.
// RULE7: Per-channel 3-bit level; highest pending level wins the request.
// RULE8: Rx-full and tx-empty map to DMA channels 0x17..0x1a; faults never.
// RULE9: DMA-selected events start DMA instead of raising an interrupt request.
// RULE10: Software sets DMA select bits and programs the DMA engine beforehand.
// RULE11: Vectors step by four from table base plus 0xe0, ch0 then ch1.
// RULE12: Flag and enable bits: ch0 fault, rx, tx at 0..2; ch1 at 3..5.
// RULE13: Tx holding is read/write, LSB first; bit 7 dropped in 7-bit mode.
// RULE14: Rx holding is read-only; bit 7 reads zero in 7-bit mode.
// RULE15: Fault bits at D4..D2 reset to 0 and clear by writing 0.
// RULE16: Tx-empty at D1 resets to 1; rx-full at D0 resets to 0.
// RULE17: Parity on, parity sense, stop length in control D5..D3, async only.
// RULE18: Control D2 picks external shift clock pin or internal clock.
// RULE19: Mode field D1:D0: 11 async8, 10 async7, 01 sync slave, 00 sync master.
// RULE20: Option D4 picks async divider: 1 for 1/8, 0 for 1/16.
// RULE21: Option D3 inverts output, D2 inverts input, only in async modes.
// RULE22: Option D1:D0 selects 10 pulse modulation or 00 plain serial.
// RULE23: Control D7 and D6 enable transmitter and receiver, reset to 0.
// RULE24: Reception before the previous byte is read overwrites it and flags overrun.
// RULE25: A zero stop bit is a framing fault; both checked with two stop bits.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module serial_evt_regs
   import serial_evt_pkg::*;
(
   input  wire logic                   clk_in,
   input  wire logic                   reset_n_in,
   input  wire logic [ADDR_W-1:0]      axi_awaddr_in,
   input  wire logic                   axi_awvalid_in,
   output logic                        axi_awready_out,
   input  wire logic [31:0]            axi_wdata_in,
   input  wire logic [3:0]             axi_wstrb_in,
   input  wire logic                   axi_wvalid_in,
   output logic                        axi_wready_out,
   output logic [1:0]                  axi_bresp_out,
   output logic                        axi_bvalid_out,
   input  wire logic                   axi_bready_in,
   input  wire logic [ADDR_W-1:0]      axi_araddr_in,
   input  wire logic                   axi_arvalid_in,
   output logic                        axi_arready_out,
   output logic [31:0]                 axi_rdata_out,
   output logic [1:0]                  axi_rresp_out,
   output logic                        axi_rvalid_out,
   input  wire logic                   axi_rready_in,
   input  wire rx_event_t [NCH-1:0]    rx_event_in,
   input  wire logic [NCH-1:0]         tx_take_in,
   output tx_feed_t [NCH-1:0]          tx_feed_out,
   output chan_cfg_t [NCH-1:0]         cfg_out,
   input  wire logic [NCH-1:0]         serial_in_pin_in,
   output logic [NCH-1:0]              rx_line_out,
   input  wire logic [NCH-1:0]         tx_line_in,
   output logic [NCH-1:0]              serial_out_pin_out,
   input  wire logic [NCH-1:0]         external_shift_clock_pin_in,
   input  wire logic [NCH-1:0]         internal_tick_in,
   output logic [NCH-1:0]              shift_clock_out,
   input  wire logic [27:0]            vector_table_base_in,
   output logic                        irq_req_out,
   output logic [2:0]                  irq_level_out,
   output logic [27:0]                 irq_vector_out,
   output logic [3:0]                  dma_req_out,
   output logic [7:0]                  dma_chan_out,
   input  wire logic [3:0]             dma_done_in
);

   state_t q;
   state_t d;

   // Register read decode: bit 8 marks a mapped index
   function automatic logic [8:0] reg_read(input state_t s, input logic [IDX_W-1:0] idx);
      logic [8:0] r;
      r = 9'h000;
      for (int i = 0; i < NCH; i++) begin
         if (idx == IDX_TX_HOLD[i]) r = {1'b1, s.ch[i].tx_hold};                       // RULE13
         if (idx == IDX_RX_HOLD[i]) r = {1'b1, s.ch[i].rx_hold};                       // RULE14
         if (idx == IDX_STATUS[i]) begin
            r = 9'h100;
            r[ST_FER]  = s.ch[i].fer;                                                  // RULE15
            r[ST_PER]  = s.ch[i].per;
            r[ST_OER]  = s.ch[i].oer;
            r[ST_TDBE] = s.ch[i].tx_empty;                                             // RULE16
            r[ST_RDBF] = s.ch[i].rx_full;
         end
         if (idx == IDX_CONTROL[i])   r = {1'b1, s.ch[i].ctl};
         if (idx == IDX_IR_OPTION[i]) r = {1'b1, 3'h0, s.ch[i].ir};
         if (idx == IDX_PRIORITY[i]) begin
            r = 9'h100;
            r[PRI_LO[i] +: 3] = s.pri[i];
         end
         if (idx == IDX_DMA_SEL[i]) begin
            r = 9'h100;
            r[DMA_RX_BIT[i]] = s.dma_sel[2*i];
            r[DMA_TX_BIT[i]] = s.dma_sel[2*i+1];
         end
      end
      if (idx == IDX_ENABLES) r = {1'b1, 2'h0, s.en};                                  // RULE12
      if (idx == IDX_FLAGS)   r = {1'b1, 2'h0, s.flg};
      return r;
   endfunction : reg_read

   always_comb begin
      logic [IDX_W-1:0] widx;
      logic [8:0]       rd;
      logic [7:0]       wb;
      logic             wr_hit;
      logic             async;
      logic             seven;
      logic [7:0]       rx_byte;
      logic             perr;
      logic             ferr;
      logic [NEV-1:0]   req;
      logic             found;
      logic [2:0]       best_lvl;
      logic [27:0]      best_ofs;
      widx     = q.awaddr[ADDR_W-1:2];
      rd       = 9'h000;
      wb       = q.wdata;
      wr_hit   = 1'b0;
      async    = 1'b0;
      seven    = 1'b0;
      rx_byte  = 8'h00;
      perr     = 1'b0;
      ferr     = 1'b0;
      req      = '0;
      found    = 1'b0;
      best_lvl = 3'h0;
      best_ofs = 28'h0000000;
      d = q;

      // Pin synchronisers
      d.rx_s1 = serial_in_pin_in;
      d.rx_s2 = q.rx_s1;
      d.ck_s1 = external_shift_clock_pin_in;
      d.ck_s2 = q.ck_s1;

      // Bus write path: address and data taken in either order
      if (axi_awvalid_in && axi_awready_out) begin
         d.aw_got = 1'b1;
         d.awaddr = axi_awaddr_in;
      end
      if (axi_wvalid_in && axi_wready_out) begin
         d.w_got  = 1'b1;
         d.wdata  = axi_wdata_in[7:0];
         d.wstrb0 = axi_wstrb_in[0];
      end
      if (q.bvalid && axi_bready_in) d.bvalid = 1'b0;
      if (q.aw_got && q.w_got && !q.bvalid) begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         wr_hit   = reg_read(q, widx) >> 8 != 9'h000;
         d.bresp  = wr_hit ? RESP_OKAY : RESP_DECERR;
         if (q.wstrb0) begin
            for (int i = 0; i < NCH; i++) begin
               if (widx == IDX_TX_HOLD[i]) begin
                  d.ch[i].tx_hold  = wb; // RULE13
                  d.ch[i].tx_empty = 1'b0;
               end
               if (widx == IDX_STATUS[i]) begin
                  if (!wb[ST_FER]) d.ch[i].fer = 1'b0; // RULE15
                  if (!wb[ST_PER]) d.ch[i].per = 1'b0;
                  if (!wb[ST_OER]) d.ch[i].oer = 1'b0;
               end
               if (widx == IDX_CONTROL[i])   d.ch[i].ctl = wb;                         // RULE23
               if (widx == IDX_IR_OPTION[i]) d.ch[i].ir  = wb[IR_W-1:0];
               if (widx == IDX_PRIORITY[i])  d.pri[i]    = wb[PRI_LO[i] +: 3];         // RULE7
               if (widx == IDX_DMA_SEL[i]) begin
                  d.dma_sel[2*i]   = wb[DMA_RX_BIT[i]]; // RULE10
                  d.dma_sel[2*i+1] = wb[DMA_TX_BIT[i]];
               end
            end
            if (widx == IDX_ENABLES) d.en = wb[NEV-1:0];
            if (widx == IDX_FLAGS)   d.flg = q.flg & ~wb[NEV-1:0];
         end
      end

      // Bus read path; reading rx holding empties it
      if (q.rvalid && axi_rready_in) d.rvalid = 1'b0;
      if (axi_arvalid_in && axi_arready_out) begin
         rd       = reg_read(q, axi_araddr_in[ADDR_W-1:2]);
         d.rvalid = 1'b1;
         d.rdata  = rd[7:0];
         d.rresp  = rd[8] ? RESP_OKAY : RESP_DECERR;
         for (int i = 0; i < NCH; i++) begin
            if (axi_araddr_in[ADDR_W-1:2] == IDX_RX_HOLD[i]) d.ch[i].rx_full = 1'b0;
         end
      end

      // DMA completion clears the serviced flag
      for (int j = 0; j < 4; j++) begin
         if (dma_done_in[j]) d.flg[(j/2)*EV_STRIDE + EV_RX + (j%2)] = 1'b0;
      end

      // Channel events: hardware sets win over any clear above
      for (int i = 0; i < NCH; i++) begin
         async = q.ch[i].ctl[CTL_MODE_LO+1];
         seven = q.ch[i].ctl[CTL_MODE_LO +: 2] == MODE_ASYNC7;
         if (!q.ch[i].ctl[CTL_TX_ON] && !q.ch[i].ctl[CTL_RX_ON]) begin
            d.ch[i].fer = 1'b0;
            d.ch[i].per = 1'b0;
            d.ch[i].oer = 1'b0;
         end
         if (tx_take_in[i] && !q.ch[i].tx_empty) begin
            d.ch[i].tx_empty = 1'b1; // RULE1
            d.flg[i*EV_STRIDE + EV_TX] = 1'b1; // RULE6
         end
         if (rx_event_in[i].done && q.ch[i].ctl[CTL_RX_ON]) begin
            rx_byte = rx_event_in[i].data;
            if (seven) rx_byte[7] = 1'b0; // RULE14
            perr = async && q.ch[i].ctl[CTL_PAR_ON] &&                                 // RULE17
                   ((^rx_byte ^ rx_event_in[i].parity) != q.ch[i].ctl[CTL_PAR_SNS]);
            ferr = async && (!rx_event_in[i].stop[0] ||                                // RULE25
                   (q.ch[i].ctl[CTL_STOP_LEN] && !rx_event_in[i].stop[1]));
            d.ch[i].rx_hold = rx_byte; // RULE24
            d.ch[i].rx_full = 1'b1; // RULE2
            d.flg[i*EV_STRIDE + EV_RX] = 1'b1; // RULE5
            if (perr) d.ch[i].per = 1'b1; // RULE4
            if (ferr) d.ch[i].fer = 1'b1;
            if (q.ch[i].rx_full) d.ch[i].oer = 1'b1; // RULE24
            if (perr || ferr || q.ch[i].rx_full) begin
               d.flg[i*EV_STRIDE + EV_ERR] = 1'b1; // RULE3
            end
         end
         // Pin logic inversion and shift clock selection
         d.rx_line[i] = q.rx_s2[i] ^ (async & q.ch[i].ir[IR_IN_INV]);                 // RULE21
         d.tx_pin[i]  = tx_line_in[i] ^ (async & q.ch[i].ir[IR_OUT_INV]);
         d.shclk[i]   = q.ch[i].ctl[CTL_CLK_SRC] ? q.ck_s2[i] : internal_tick_in[i];  // RULE18
      end

      // DMA triggers for rx-full and tx-empty, lowest index reported first
      d.dma_chan = 8'h00;
      for (int j = 3; j >= 0; j--) begin
         d.dma_req[j] = q.flg[(j/2)*EV_STRIDE + EV_RX + (j%2)] & q.dma_sel[j];        // RULE9
         if (d.dma_req[j]) d.dma_chan = DMA_CH_NUM[j]; // RULE8
      end

      // Interrupt selection: highest level, then lower source index
      for (int k = 0; k < NEV; k++) begin
         req[k] = q.flg[k] & q.en[k]; // RULE6
         if ((k % EV_STRIDE) != EV_ERR) begin
            req[k] = req[k] & ~q.dma_sel[(k/EV_STRIDE)*2 + (k%EV_STRIDE) - 1];        // RULE9
         end
      end
      for (int k = NEV-1; k >= 0; k--) begin
         if (req[k] && (!found || q.pri[k/EV_STRIDE] >= best_lvl)) begin              // RULE7
            found    = 1'b1;
            best_lvl = q.pri[k/EV_STRIDE];
            best_ofs = VEC_FIRST_OFS + VEC_STEP * 28'(k);                              // RULE11
         end
      end
      d.irq_req    = found;
      d.irq_level  = best_lvl;
      d.irq_vector = vector_table_base_in + best_ofs;
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         q       <= '0;
         q.ch[0] <= CHAN_RESET; // RULE16
         q.ch[1] <= CHAN_RESET;
      end else begin
         q <= d;
      end
   end

   // Bus handshakes: one write and one read in flight
   assign axi_awready_out = !q.aw_got && !q.bvalid;
   assign axi_wready_out  = !q.w_got && !q.bvalid;
   assign axi_bvalid_out  = q.bvalid;
   assign axi_bresp_out   = q.bresp;
   assign axi_arready_out = !q.rvalid;
   assign axi_rvalid_out  = q.rvalid;
   assign axi_rdata_out   = {24'h000000, q.rdata};
   assign axi_rresp_out   = q.rresp;

   assign rx_line_out        = q.rx_line;
   assign serial_out_pin_out = q.tx_pin;
   assign shift_clock_out    = q.shclk;
   assign irq_req_out        = q.irq_req;
   assign irq_level_out      = q.irq_level;
   assign irq_vector_out     = q.irq_vector;
   assign dma_req_out        = q.dma_req;
   assign dma_chan_out       = q.dma_chan;

   // Shift engine feed and configuration view
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         tx_feed_out[i].valid = !q.ch[i].tx_empty && q.ch[i].ctl[CTL_TX_ON];
         tx_feed_out[i].data  = q.ch[i].tx_hold;
         if (q.ch[i].ctl[CTL_MODE_LO +: 2] == MODE_ASYNC7) begin
            tx_feed_out[i].data[7] = 1'b0; // RULE13
         end
         cfg_out[i].transmitter_on       = q.ch[i].ctl[CTL_TX_ON];                     // RULE23
         cfg_out[i].receiver_on          = q.ch[i].ctl[CTL_RX_ON];
         cfg_out[i].parity_on            = q.ch[i].ctl[CTL_PAR_ON]                     // RULE17
                                           & q.ch[i].ctl[CTL_MODE_LO+1];
         cfg_out[i].parity_sense         = q.ch[i].ctl[CTL_PAR_SNS];
         cfg_out[i].stop_length          = q.ch[i].ctl[CTL_STOP_LEN];
         cfg_out[i].transfer_mode_field  = q.ch[i].ctl[CTL_MODE_LO +: 2];             // RULE19
         cfg_out[i].async_divider_select = q.ch[i].ir[IR_DIV];                         // RULE20
         cfg_out[i].interface_mode_field = q.ch[i].ir[IR_MODE_LO +: 2];               // RULE22
      end
   end
endmodule : serial_evt_regs

// ===== sim/serial_evt_properties.sv
// Port assertions for the serial event block
`timescale 1ns/1ps
module serial_evt_props
   import serial_evt_pkg::*;
(
   input wire logic                clk_in,
   input wire logic                reset_n_in,
   input wire logic                axi_bvalid_out,
   input wire logic                axi_bready_in,
   input wire logic                axi_arvalid_in,
   input wire logic                axi_arready_out,
   input wire logic                axi_rvalid_out,
   input wire logic                axi_rready_in,
   input wire logic [31:0]         axi_rdata_out,
   input wire tx_feed_t [NCH-1:0]  tx_feed_out,
   input wire chan_cfg_t [NCH-1:0] cfg_out,
   input wire logic [NCH-1:0]      tx_line_in,
   input wire logic [NCH-1:0]      serial_out_pin_out,
   input wire logic [NCH-1:0]      serial_in_pin_in,
   input wire logic [NCH-1:0]      rx_line_out,
   input wire logic [27:0]         vector_table_base_in,
   input wire logic                irq_req_out,
   input wire logic [27:0]         irq_vector_out,
   input wire logic [3:0]          dma_req_out,
   input wire logic [7:0]          dma_chan_out
);
   wire logic [27:0] vec_ofs = irq_vector_out - vector_table_base_in;
   wire logic        sync0   = !cfg_out[0].transfer_mode_field[1];
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);
   chk_dma_number: assert property (dma_req_out[0] |-> dma_chan_out == 8'h17)
      else $error("dma channel number wrong");
   chk_vector_range: assert property (irq_req_out |-> vec_ofs >= 28'he0
      && vec_ofs <= 28'hf4 && vec_ofs[1:0] == 2'h0)
      else $error("vector outside table");
   chk_tx_seven: assert property (tx_feed_out[0].valid
      && cfg_out[0].transfer_mode_field == MODE_ASYNC7 |-> !tx_feed_out[0].data[7])
      else $error("bit 7 sent in 7-bit mode");
   chk_parity_gate: assert property (sync0 |-> !cfg_out[0].parity_on)
      else $error("parity active in sync mode");
   chk_out_direct: assert property (sync0
      |=> serial_out_pin_out[0] == $past(tx_line_in[0]))
      else $error("output pin altered");
   chk_in_direct: assert property (sync0 [*4]
      |-> rx_line_out[0] == $past(serial_in_pin_in[0], 3))
      else $error("input line altered");
   chk_bvalid_hold: assert property (axi_bvalid_out && !axi_bready_in |=> axi_bvalid_out)
      else $error("write response dropped");
   chk_rvalid_hold: assert property (axi_rvalid_out && !axi_rready_in
      |=> axi_rvalid_out && $stable(axi_rdata_out))
      else $error("read data dropped");
   chk_read_answer: assert property (axi_arvalid_in && axi_arready_out |=> axi_rvalid_out)
      else $error("read not answered");
   chk_ar_block: assert property (axi_rvalid_out |-> !axi_arready_out)
      else $error("read address taken early");
   cov_irq: cover property (irq_req_out);
   cov_dma: cover property (dma_req_out[0]);
   cov_write: cover property (axi_bvalid_out && axi_bready_in);
endmodule : serial_evt_props

// ===== sim/serial_peer.sv
// Shift engine and serial peer model for one channel
`timescale 1ns/1ps
module serial_peer
   import serial_evt_pkg::*;
(
   input  wire logic      clk_in,
   input  wire logic      reset_n_in,
   input  wire rx_event_t send_in,
   input  wire tx_feed_t  feed_in,
   input  wire logic      slow_in,
   output rx_event_t      rx_event_out,
   output logic           tx_take_out,
   output logic [7:0]     got_out
);
   logic [2:0] wait_q;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rx_event_out <= '0;
         tx_take_out <= 1'b0;
         got_out <= 8'h00;
         wait_q <= 3'h0;
      end else begin
         rx_event_out <= send_in;
         tx_take_out <= 1'b0;
         if (feed_in.valid && !tx_take_out) begin
            wait_q <= wait_q + 3'h1;
            if (wait_q >= {slow_in, 2'b00}) begin
               tx_take_out <= 1'b1;
               got_out <= feed_in.data;
               wait_q <= 3'h0;
            end
         end
      end
   end
endmodule : serial_peer

// ===== sim/tb.sv
// Self-checking bench for the serial event block
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb
   import serial_evt_pkg::*;
;
   logic clk_in = 1'b0, reset_n_in = 1'b0;
   logic [ADDR_W-1:0] axi_awaddr_in = '0, axi_araddr_in = '0;
   logic axi_awvalid_in = 1'b0, axi_wvalid_in = 1'b0, axi_bready_in = 1'b0;
   logic axi_arvalid_in = 1'b0, axi_rready_in = 1'b0;
   logic [31:0] axi_wdata_in = 32'h0, axi_rdata_out;
   logic [3:0] axi_wstrb_in = 4'hf, dma_done_in = 4'h0, dma_req_out;
   logic axi_awready_out, axi_wready_out, axi_bvalid_out, axi_arready_out, axi_rvalid_out;
   logic [1:0] axi_bresp_out, axi_rresp_out, r;
   rx_event_t send = '0, pe;
   logic pt, irq_req_out;
   wire rx_event_t [NCH-1:0] rx_event_in = {rx_event_t'(0), pe};
   wire logic [NCH-1:0] tx_take_in = {1'b0, pt};
   tx_feed_t [NCH-1:0] tx_feed_out;
   chan_cfg_t [NCH-1:0] cfg_out;
   logic [NCH-1:0] serial_in_pin_in = '0, tx_line_in = '0, external_shift_clock_pin_in = '0;
   logic [NCH-1:0] internal_tick_in = '0, rx_line_out, serial_out_pin_out, shift_clock_out;
   logic [27:0] vector_table_base_in = 28'h0c00000, irq_vector_out;
   logic [2:0] irq_level_out;
   logic [7:0] dma_chan_out, got, mask = 8'hff;
   logic [31:0] seed = 32'h0000000e;
   int fail_count = 0, cmp_count = 0, cyc = 0;
   int rxq[$];
   serial_evt_regs dut (.*);
   serial_peer u_peer (.clk_in, .reset_n_in, .send_in(send), .feed_in(tx_feed_out[0]),
      .slow_in(seed[9]), .rx_event_out(pe), .tx_take_out(pt), .got_out(got));
   always #50 clk_in = !clk_in;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   task automatic final_report();
      if (fail_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   always @(posedge clk_in) begin
      seed <= xs(seed);
      {internal_tick_in, external_shift_clock_pin_in, tx_line_in, serial_in_pin_in} <= seed[7:0];
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end
   task automatic wr(input logic [19:0] i, input logic [7:0] v);
      @(posedge clk_in);
      axi_awaddr_in <= {i, 2'b00};
      axi_wdata_in <= {24'h000000, v};
      {axi_awvalid_in, axi_wvalid_in, axi_bready_in} <= 3'h7;
      do begin
         @(posedge clk_in);
         if (axi_awready_out) axi_awvalid_in <= 1'b0;
         if (axi_wready_out) axi_wvalid_in <= 1'b0;
      end while (!axi_bvalid_out);
      axi_bready_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [19:0] i, output logic [1:0] rr);
      @(posedge clk_in);
      axi_araddr_in <= {i, 2'b00};
      {axi_arvalid_in, axi_rready_in} <= 2'h3;
      do begin
         @(posedge clk_in);
         if (axi_arready_out) axi_arvalid_in <= 1'b0;
      end while (!axi_rvalid_out);
      rr = axi_rresp_out;
      axi_rready_in <= 1'b0;
   endtask : rd
   task automatic rc(input logic [19:0] i, input logic [7:0] e);
      rd(i, r);
      `CHK({r, axi_rdata_out}, {RESP_OKAY, 24'h0, e})
   endtask : rc
   task automatic recv(input logic flip, input logic [1:0] s);
      logic [7:0] b;
      b = {1'b1, seed[14:8]};
      rxq.push_back(b & mask);
      @(posedge clk_in);
      send <= '{1'b1, b, (^b) ^ flip, s};
      @(posedge clk_in);
      send <= '0;
      repeat (3) @(posedge clk_in);
   endtask : recv
   initial begin
      repeat (2) @(posedge clk_in);
      reset_n_in <= 1'b1;
      rc(IDX_STATUS[0], 8'h02);
      rc(IDX_CONTROL[1], 8'h00);
      rd(20'h40265, r);
      `CHK({r, axi_rdata_out}, {RESP_DECERR, 32'h0})
      wr(IDX_ENABLES, 8'h02);
      wr(IDX_PRIORITY[0], 8'h50);
      wr(IDX_CONTROL[0], 8'hc3);
      recv(1'b0, 2'b11);
      `CHK({irq_req_out, irq_level_out}, 4'hd)
      `CHK(irq_vector_out, 28'h0c000e4)
      rc(IDX_FLAGS, 8'h02);
      rc(IDX_STATUS[0], 8'h03);
      rc(IDX_RX_HOLD[0], rxq.pop_front());
      wr(IDX_FLAGS, 8'h3f);
      recv(1'b0, 2'b11);
      recv(1'b0, 2'b11);
      rc(IDX_STATUS[0], 8'h07);
      rc(IDX_FLAGS, 8'h03);
      void'(rxq.pop_front());
      rc(IDX_RX_HOLD[0], rxq.pop_front());
      wr(IDX_STATUS[0], 8'h00);
      rc(IDX_STATUS[0], 8'h02);
      wr(IDX_CONTROL[0], 8'he3);
      for (int k = 0; k < 2; k++) begin
         wr(IDX_FLAGS, 8'h3f);
         recv(k == 0, k ? 2'b10 : 2'b11);
         rc(IDX_STATUS[0], k ? 8'h13 : 8'h0b);
         rc(IDX_FLAGS, 8'h03);
         rc(IDX_RX_HOLD[0], rxq.pop_front());
         wr(IDX_STATUS[0], 8'h00);
      end
      wr(IDX_CONTROL[0], 8'h60);
      recv(1'b1, 2'b00);
      rc(IDX_STATUS[0], 8'h03);
      void'(rxq.pop_front());
      wr(IDX_CONTROL[0], 8'hc2);
      mask = 8'h7f;
      recv(1'b0, 2'b11);
      rc(IDX_RX_HOLD[0], rxq.pop_front());
      wr(IDX_FLAGS, 8'h3f);
      wr(IDX_TX_HOLD[0], 8'hff);
      repeat (10) @(posedge clk_in);
      `CHK(got, 8'h7f)
      rc(IDX_TX_HOLD[0], 8'hff);
      rc(IDX_FLAGS, 8'h04);
      wr(IDX_FLAGS, 8'h3f);
      wr(IDX_DMA_SEL[0], 8'h40);
      recv(1'b0, 2'b11);
      `CHK({irq_req_out, dma_req_out, dma_chan_out}, {5'h01, 8'h17})
      @(posedge clk_in);
      dma_done_in <= 4'h1;
      @(posedge clk_in);
      dma_done_in <= 4'h0;
      repeat (2) @(posedge clk_in);
      `CHK(dma_req_out, 4'h0)
      final_report();
   end
endmodule : tb
bind serial_evt_regs serial_evt_props u_props (.*);
